// File: alu_bit_decode.v
/*
  decode and execute of accumulator add/sub, logic, rotate, nibble swap
  and carry-bit instructions of an 8-bit core.
  assumes: program memory answers a fetch request with code_valid;
  data memory read data is valid in the cycle mem_rd is high and held until the next read; register
  operands arrive from the core register file on reg_data.
*/
//Contract
//RULE1 - add without carry: reg 1B/1c, direct and immediate 2B/2c
//RULE2 - add with carry: reg 1c, direct and immediate 2B/2c
//RULE3 - subtract with borrow: reg 1c, direct and immediate 2B/2c
//RULE4 - and into accumulator: reg 1c, direct and immediate 2B/2c
//RULE5 - and into direct byte, from accumulator 2B or immediate 3B, 3c
//RULE6 - or into accumulator: reg 1c, direct and immediate 2B/2c
//RULE7 - or into direct byte, from accumulator 2B or immediate 3B, 3c
//RULE8 - xor into accumulator: reg 1c, direct and immediate 2B/2c
//RULE9 - xor into direct byte, from accumulator 2B or immediate 3B, 3c
//RULE10 - rotate left plain or through carry, 1B 1c
//RULE11 - rotate right plain or through carry, 1B 1c
//RULE12 - swap accumulator nibbles, 1B 4c
//RULE13 - carry becomes carry and direct bit, 2B 2c
//RULE14 - carry becomes carry and inverted direct bit, 2B 2c
//RULE15 - carry becomes carry or direct bit, 2B 2c
//RULE16 - carry becomes carry or inverted direct bit, 2B 2c
//RULE17 - direct bit copied into carry, 2B 2c
//RULE18 - carry written into direct bit, 2B 3c
//RULE19 - fetch all operand bytes, wait out cycle count before next fetch
`timescale 1ns/1ps
`default_nettype none
`include "alu_decode_defs.vh"

module alu_bit_decode #(
  parameter DW = 8
) (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // program memory
  output wire code_req,
  input wire code_valid,
  input wire [7:0] code_byte,
  // register file operand
  input wire [DW-1:0] reg_data,
  // internal data memory
  output reg mem_rd,
  output reg mem_wr,
  output reg [7:0] mem_addr,
  output reg [DW-1:0] mem_wdata,
  input wire [DW-1:0] mem_rdata,
  // core state
  output reg [DW-1:0] acc_q,
  output reg carry_q,
  output reg busy,
  output reg insn_done,
  output reg illegal_op
);

  localparam S_OP = 3'd0;
  localparam S_B2 = 3'd1;
  localparam S_B3 = 3'd2;
  localparam S_EX = 3'd3;
  localparam S_WAIT = 3'd4;

  reg [2:0] state_q;
  reg [7:0] op_q;
  reg [7:0] b2_q;
  reg [7:0] b3_q;
  reg [2:0] cyc_q;
  reg [2:0] need_q;
  reg [1:0] len_q;

  // class of the opcode on code_byte
  reg [1:0] len_d;
  reg [2:0] need_d;
  reg known_d;
  always @* begin
    len_d = 2'd1;
    need_d = `CYC_ONE;
    known_d = 1'b1;
    case (code_byte)
      `OP_ADD_DIR, `OP_ADD_IMM, `OP_SUMC_DIR, `OP_SUMC_IMM,
      `OP_SUBC_DIR, `OP_SUBC_IMM, `OP_AND_DIR, `OP_AND_IMM,
      `OP_OR_DIR, `OP_OR_IMM, `OP_XOR_DIR, `OP_XOR_IMM,
      `OP_CAND, `OP_CANDN, `OP_COR, `OP_CORN, `OP_CMOV: begin
        len_d = 2'd2; //RULE19
        need_d = `CYC_TWO;
      end
      `OP_AND_MA, `OP_OR_MA, `OP_XOR_MA, `OP_BMOV: begin
        len_d = 2'd2;
        need_d = `CYC_WB;
      end
      `OP_AND_MI, `OP_OR_MI, `OP_XOR_MI: begin
        len_d = 2'd3;
        need_d = `CYC_WB;
      end
      `OP_SWAP: need_d = `CYC_SWAP; //RULE12
      `OP_ROL, `OP_ROLC, `OP_ROR, `OP_RORC: need_d = `CYC_ONE;
      default: begin
        case (code_byte[7:3])
          `OP_ADD_REG, `OP_SUMC_REG, `OP_SUBC_REG, `OP_AND_REG,
          `OP_OR_REG, `OP_XOR_REG: need_d = `CYC_ONE;
          default: known_d = 1'b0;
        endcase
      end
    endcase
  end

  // register, direct operand or immediate
  wire is_imm = (op_q[3:0] == 4'h4);
  wire is_reg = op_q[3];
  wire [DW-1:0] src = is_reg ? reg_data : (is_imm ? b2_q : mem_rdata);
  // bit address: 00-7F bytes 20-2F, 80-FF sfr byte with low bits cleared
  wire [7:0] bit_byte = b2_q[7] ? {b2_q[7:3], 3'h0} :
    {4'h2, b2_q[6:3]};
  wire dbit = mem_rdata[b2_q[2:0]];

  wire [DW:0] sum_add = {1'b0, acc_q} + {1'b0, src};
  wire [DW:0] sum_sum_with_carry_in = sum_add + {{DW{1'b0}}, carry_q};
  wire [DW:0] dif_subtract_borrow = {1'b0, acc_q} - {1'b0, src} -
    {{DW{1'b0}}, carry_q};

  assign code_req = (state_q == S_OP) || (state_q == S_B2) ||
    (state_q == S_B3);

  always @(posedge core_clk) begin
    if (!rst_n) begin
      state_q <= S_OP;
      op_q <= 8'h00;
      b2_q <= 8'h00;
      b3_q <= 8'h00;
      cyc_q <= 3'h0;
      need_q <= 3'h0;
      len_q <= 2'd0;
      acc_q <= {DW{1'b0}};
      carry_q <= 1'b0;
      busy <= 1'b0;
      insn_done <= 1'b0;
      illegal_op <= 1'b0;
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      mem_addr <= 8'h00;
      mem_wdata <= {DW{1'b0}};
    end else begin
      insn_done <= 1'b0;
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      illegal_op <= 1'b0;
      if (state_q != S_OP)
        cyc_q <= cyc_q + 3'h1;
      case (state_q)
        S_OP: if (code_valid) begin
          op_q <= code_byte;
          busy <= 1'b1;
          cyc_q <= 3'h1;
          need_q <= need_d;
          len_q <= len_d;
          illegal_op <= ~known_d;
          if (!known_d) begin
            busy <= 1'b0;
          end else if (len_d == 2'd1) begin
            state_q <= S_EX;
          end else begin
            state_q <= S_B2;
          end
        end
        S_B2: if (code_valid) begin
          b2_q <= code_byte; //RULE19
          mem_addr <= (op_q[3:0] == 4'h2 || op_q[3:0] == 4'h0) ?
            ((op_q == `OP_AND_MA || op_q == `OP_OR_MA ||
            op_q == `OP_XOR_MA) ? code_byte :
            (code_byte[7] ? {code_byte[7:3], 3'h0} :
            {4'h2, code_byte[6:3]})) : code_byte;
          mem_rd <= (op_q[3:0] != 4'h4);
          state_q <= (len_q == 2'd3) ? S_B3 : S_EX;
        end
        S_B3: if (code_valid) begin
          b3_q <= code_byte;
          state_q <= S_EX;
        end
        S_EX: begin
          state_q <= S_WAIT;
          case (op_q)
            `OP_ROL: acc_q <= {acc_q[DW-2:0], acc_q[DW-1]}; //RULE10
            `OP_ROLC: begin
              acc_q <= {acc_q[DW-2:0], carry_q}; //RULE10
              carry_q <= acc_q[DW-1];
            end
            `OP_ROR: acc_q <= {acc_q[0], acc_q[DW-1:1]}; //RULE11
            `OP_RORC: begin
              acc_q <= {carry_q, acc_q[DW-1:1]}; //RULE11
              carry_q <= acc_q[0];
            end
            // swap lands at the last cycle so acc only moves with done
            `OP_SWAP: acc_q <= acc_q; //RULE12
            `OP_CAND: carry_q <= carry_q & dbit; //RULE13
            `OP_CANDN: carry_q <= carry_q & ~dbit; //RULE14
            `OP_COR: carry_q <= carry_q | dbit; //RULE15
            `OP_CORN: carry_q <= carry_q | ~dbit; //RULE16
            `OP_CMOV: carry_q <= dbit; //RULE17
            `OP_BMOV: begin
              mem_wr <= 1'b1; //RULE18
              mem_addr <= bit_byte;
              mem_wdata <= mem_rdata;
              mem_wdata[b2_q[2:0]] <= carry_q;
            end
            `OP_AND_MA: begin
              mem_wr <= 1'b1; //RULE5
              mem_wdata <= mem_rdata & acc_q;
            end
            `OP_AND_MI: begin
              mem_wr <= 1'b1; //RULE5
              mem_wdata <= mem_rdata & b3_q;
            end
            `OP_OR_MA: begin
              mem_wr <= 1'b1; //RULE7
              mem_wdata <= mem_rdata | acc_q;
            end
            `OP_OR_MI: begin
              mem_wr <= 1'b1; //RULE7
              mem_wdata <= mem_rdata | b3_q;
            end
            `OP_XOR_MA: begin
              mem_wr <= 1'b1; //RULE9
              mem_wdata <= mem_rdata ^ acc_q;
            end
            `OP_XOR_MI: begin
              mem_wr <= 1'b1; //RULE9
              mem_wdata <= mem_rdata ^ b3_q;
            end
            default: begin
              case (op_q[7:4])
                4'h2: begin
                  acc_q <= sum_add[DW-1:0]; //RULE1
                  carry_q <= sum_add[DW];
                end
                4'h3: begin
                  acc_q <= sum_sum_with_carry_in[DW-1:0]; //RULE2
                  carry_q <= sum_sum_with_carry_in[DW];
                end
                4'h9: begin
                  acc_q <= dif_subtract_borrow[DW-1:0]; //RULE3
                  carry_q <= dif_subtract_borrow[DW];
                end
                4'h5: acc_q <= acc_q & src; //RULE4
                4'h4: acc_q <= acc_q | src; //RULE6
                4'h6: acc_q <= acc_q ^ src; //RULE8
                default: acc_q <= acc_q;
              endcase
            end
          endcase
          if (cyc_q >= need_q) begin
            state_q <= S_OP;
            busy <= 1'b0;
            insn_done <= 1'b1;
          end
        end
        S_WAIT: if (cyc_q >= need_q) begin
          state_q <= S_OP; //RULE19
          if (op_q == `OP_SWAP)
            acc_q <= {acc_q[3:0], acc_q[7:4]}; //RULE12
          busy <= 1'b0;
          insn_done <= 1'b1;
        end
        default: state_q <= S_OP;
      endcase
    end
  end

endmodule
`default_nettype wire

// File: alu_decode_defs.vh
/*
  opcodes and cycle counts for the accumulator
  arithmetic, logic, rotate and boolean groups.
  assumes: included by alu_bit_decode.v only, by bare name.
*/
`ifndef ALU_DECODE_DEFS_VH
`define ALU_DECODE_DEFS_VH

`define OP_ADD_DIR 8'h25
`define OP_ADD_IMM 8'h24
`define OP_ADD_REG 5'h05
`define OP_SUMC_DIR 8'h35
`define OP_SUMC_IMM 8'h34
`define OP_SUMC_REG 5'h07
`define OP_SUBC_DIR 8'h95
`define OP_SUBC_IMM 8'h94
`define OP_SUBC_REG 5'h13
`define OP_AND_DIR 8'h55
`define OP_AND_IMM 8'h54
`define OP_AND_REG 5'h0B
`define OP_AND_MA 8'h52
`define OP_AND_MI 8'h53
`define OP_OR_DIR 8'h45
`define OP_OR_IMM 8'h44
`define OP_OR_REG 5'h09
`define OP_OR_MA 8'h42
`define OP_OR_MI 8'h43
`define OP_XOR_DIR 8'h65
`define OP_XOR_IMM 8'h64
`define OP_XOR_REG 5'h0D
`define OP_XOR_MA 8'h62
`define OP_XOR_MI 8'h63
`define OP_ROL 8'h23
`define OP_ROLC 8'h33
`define OP_ROR 8'h03
`define OP_RORC 8'h13
`define OP_SWAP 8'hC4
`define OP_CAND 8'h82
`define OP_CANDN 8'hB0
`define OP_COR 8'h72
`define OP_CORN 8'hA0
`define OP_CMOV 8'hA2
`define OP_BMOV 8'h92

`define CYC_SWAP 3'h4
`define CYC_WB 3'h3
`define CYC_TWO 3'h2
`define CYC_ONE 3'h1

`endif

// File: alu_bit_decode_chk.sv
/* port checker for the alu and bit decoder.
   assumes: bound to alu_bit_decode, one clock, sync reset. */
`timescale 1ns/1ps
`default_nettype none
module alu_bit_decode_chk (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // watched outputs
  input wire logic code_req,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] acc_q,
  input wire logic carry_q,
  input wire logic busy,
  input wire logic insn_done,
  input wire logic illegal_op
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  a_req_after_rst: assert property ($rose(rst_n) |-> code_req)
    else $error("no fetch after reset");
  a_done_one_pulse: assert property (insn_done |=> !insn_done)
    else $error("done held");
  a_done_not_busy: assert property (insn_done |-> !busy)
    else $error("busy at done");
  a_wr_at_done: assert property (mem_wr |-> ##[0:1] insn_done)
    else $error("write off done");
  a_read_then_done: assert property (mem_rd |-> ##[1:3] insn_done)
    else $error("read not finished");
  a_acc_at_done: assert property ($changed(acc_q) |-> insn_done)
    else $error("acc moved early");
  a_carry_at_done: assert property ($changed(carry_q) |-> insn_done)
    else $error("carry moved early");
  a_refuse_quiet: assert property (illegal_op |-> !mem_wr &&
    !insn_done && $stable(acc_q) && $stable(carry_q))
    else $error("refused op acted");
endmodule
bind alu_bit_decode alu_bit_decode_chk chk_u (.core_clk, .rst_n, .code_req,
  .mem_rd, .mem_wr, .acc_q, .carry_q, .busy, .insn_done, .illegal_op);
`default_nettype wire

// File: code_data_mem.sv
/* program and data memory beside the decoder.
   assumes: bench queues code bytes with put() just after an edge. */
`timescale 1ns/1ps
`default_nettype none
module code_data_mem (
  // clock
  input wire logic core_clk,
  // program memory
  input wire logic code_req,
  output var logic code_valid,
  output var logic [7:0] code_byte,
  // data memory
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output var logic [7:0] mem_rdata
);
  logic [7:0] mem [256];
  logic [7:0] q [$];
  logic [7:0] rd_addr = 8'h00;
  initial begin
    code_valid = 1'b0;
    code_byte = 8'h5A;
  end
  // read data stands from the read pulse until the next read or a write to that byte
  always_comb mem_rdata = mem[mem_rd ? mem_addr : rd_addr];
  task put(input logic [7:0] b);
    q.push_back(b);
    code_valid = 1'b1;
    code_byte = q[0];
  endtask
  always @(posedge core_clk) begin
    if (mem_wr)
      mem[mem_addr] <= mem_wdata;
    if (mem_rd)
      rd_addr <= mem_addr;
    // empty bus shows inverted data so a stale byte never passes
    if (code_req && code_valid) begin
      void'(q.pop_front());
      code_valid <= q.size() != 0;
      code_byte <= q.size() != 0 ? q[0] : ~code_byte;
    end
  end
endmodule
`default_nettype wire

// File: tb_cpu_alu_bit_instruction_decode.sv
/* bench: every opcode with random operands against a reference model.
   assumes: decoder, memory partner and checker compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
  n_tests++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); \
  end \
end
module tb_cpu_alu_bit_instruction_decode;
  logic core_clk, rst_n, code_req, code_valid, mem_rd, mem_wr, ec;
  logic busy, insn_done, illegal_op, carry_q;
  logic [7:0] code_byte, reg_data, mem_addr, mem_wdata, mem_rdata, acc_q, ea;
  logic [7:0] em [256];
  logic [7:0] ops [35] = '{8'h28, 8'h25, 8'h24, 8'h38, 8'h35, 8'h34, 8'h98,
    8'h95, 8'h94, 8'h58, 8'h55, 8'h54, 8'h52, 8'h53, 8'h48, 8'h45, 8'h44,
    8'h42, 8'h43, 8'h68, 8'h65, 8'h64, 8'h62, 8'h63, 8'h23, 8'h33, 8'h03,
    8'h13, 8'hC4, 8'h82, 8'hB0, 8'h72, 8'hA0, 8'hA2, 8'h92};
  int n_errors = 0;
  int n_tests = 0;
  int ofs = -99;
  alu_bit_decode dut_u (.core_clk, .rst_n, .code_req, .code_valid,
    .code_byte, .reg_data, .mem_rd, .mem_wr, .mem_addr, .mem_wdata,
    .mem_rdata, .acc_q, .carry_q, .busy, .insn_done, .illegal_op);
  code_data_mem pm (.core_clk, .code_req, .code_valid, .code_byte, .mem_rd,
    .mem_wr, .mem_addr, .mem_wdata, .mem_rdata);
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic run(input logic [7:0] op);
    logic [7:0] b2, b3, rg, ba, y, z;
    logic one, wb;
    int nb, nc, d;
    {b2, b3, rg, ba} = $urandom;
    if (op[3])
      op[2:0] = b3[2:0];
    one = op[3] | (op[3:0] == 4'h3 && op[7:6] == 2'b00) | op == 8'hC4 |
      op == 8'hE4;
    wb = op[7:4] inside {4'h4, 4'h5, 4'h6} && op[3:1] == 3'b001;
    nb = one ? 1 : wb && op[0] ? 3 : 2;
    nc = op == 8'hC4 ? 4 : wb || op == 8'h92 ? 3 : one ? 1 : 2;
    ba = b2[7] ? b2 & 8'hF8 : 8'h20 + b2[6:3];
    case (op)
      8'hE4: ;
      8'h23: ea = {ea[6:0], ea[7]};
      8'h33: {ec, ea} = {ea, ec};
      8'h03: ea = {ea[0], ea[7:1]};
      8'h13: {ea, ec} = {ec, ea};
      8'hC4: ea = {ea[3:0], ea[7:4]};
      8'h82: ec = ec & em[ba][b2[2:0]];
      8'hB0: ec = ec & ~em[ba][b2[2:0]];
      8'h72: ec = ec | em[ba][b2[2:0]];
      8'hA0: ec = ec | ~em[ba][b2[2:0]];
      8'hA2: ec = em[ba][b2[2:0]];
      8'h92: em[ba][b2[2:0]] = ec;
      default: begin
        y = wb ? em[b2] : ea;
        z = wb ? (op[0] ? b3 : ea) : op[3] ? rg : op[0] ? em[b2] : b2;
        case (op[7:4])
          4'h2: {ec, y} = y + z;
          4'h3: {ec, y} = y + z + ec;
          4'h9: {ec, y} = {1'b0, y} - z - ec;
          4'h5: y = y & z;
          4'h4: y = y | z;
          default: y = y ^ z;
        endcase
        if (wb)
          em[b2] = y;
        else
          ea = y;
      end
    endcase
    reg_data = rg;
    pm.put(op);
    if (nb > 1)
      pm.put(b2);
    if (nb > 2)
      pm.put(b3);
    d = 0;
    while ((op == 8'hE4 ? illegal_op : insn_done) !== 1'b1 && d < 30) begin
      @(posedge core_clk);
      #1;
      d++;
    end
    if (d == 30) begin
      n_errors++;
      give_verdict();
    end
    if (ofs == -99)
      ofs = d - nc;
    if (op != 8'hE4)
      `CHK(d - ofs, nc)
    @(posedge core_clk);
    #1;
    `CHK(acc_q, ea)
    `CHK(carry_q, ec)
    `CHK(pm.mem[b2], em[b2])
    `CHK(pm.mem[ba], em[ba])
  endtask
  initial begin
    rst_n = 1'b0;
    reg_data = 8'h00;
    void'($urandom(32'h19EFF13E));
    foreach (em[k]) begin
      em[k] = 8'($urandom);
      pm.mem[k] = em[k];
    end
    // second pass resets mid-run, then picks opcodes at random
    for (int r = 0; r < 2; r++) begin
      rst_n = 1'b0;
      ea = 8'h00;
      ec = 1'b0;
      repeat (3) @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      `CHK(acc_q, 8'h00)
      for (int k = 0; k < 140; k++)
        run(ops[r ? $urandom % 35 : k % 35]);
      $display("opcode sweep %0d done", r);
    end
    run(8'hE4);
    run(ops[0]);
    $display("refused opcode test done");
    give_verdict();
  end
endmodule
`default_nettype wire
